// [rtl/adss_map.svh]
/*
 Register offsets, field positions, reset values and timing counts of the scan sequencer.
 Assumes a 10 MHz peripheral clock and a word-wide register port with an 8-bit address.
*/
`ifndef ADSS_MAP_SVH
`define ADSS_MAP_SVH

// Register word addresses
`define ADSS_ADDR_CTRL       8'h00
`define ADSS_ADDR_STAT       8'h01
`define ADSS_ADDR_TRIG       8'h02
`define ADSS_ADDR_RES0       8'h08

// Control register fields
`define ADSS_CTRL_START      0
`define ADSS_CTRL_MODE_LO    1
`define ADSS_CTRL_MODE_HI    2
`define ADSS_CTRL_STBY       3

// Control/status register fields
`define ADSS_STAT_FLAG       0
`define ADSS_STAT_IE         1
`define ADSS_STAT_CH_LO      2
`define ADSS_STAT_CH_HI      4

// Trigger select register fields
`define ADSS_TRIG_EXT        0
`define ADSS_TRIG_TMR        1

// Mode codes
`define ADSS_MODE_SINGLE     2'h0
`define ADSS_MODE_CONT       2'h1
`define ADSS_MODE_ONECYC     2'h2

// Reset values
`define ADSS_MODE_RST        2'h0
`define ADSS_CHSEL_RST       3'h0
`define ADSS_RES_RST         10'h000

// Timing: a conversion takes 2000 ns on a 25 MHz peripheral clock, so its length is a
// fixed count of peripheral clocks whatever the clock really runs at
`define ADSS_CONV_TIME_NS    2000
`define ADSS_CONV_REF_MHZ    25
`define ADSS_CONV_CYCLES     ((`ADSS_CONV_TIME_NS * `ADSS_CONV_REF_MHZ) / 1000)

`endif

// [rtl/adss_pkg.sv]
/*
 Types shared by the scan sequencer files.
 Assumes the constants of adss_map.svh are included where offsets are needed.
*/
package adss_pkg;
   typedef enum logic {ADSS_IDLE, ADSS_CONV} adss_state_e;
   typedef logic [9:0] adss_code_t;
endpackage

// [rtl/adss_conv_timer.sv]
/*
 Per-channel conversion timer: holds the converter busy for a fixed count of clocks,
 then captures the analog front end's 10-bit code and pulses done.
 Assumes the code input is settled and synchronous to clk by the end of the count.
*/
`timescale 1ns/1ps
`include "adss_map.svh"

module adss_conv_timer #(
   parameter int CYCLES = `ADSS_CONV_CYCLES
) (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               go,
   input  wire logic               abort,
   input  wire adss_pkg::adss_code_t analog_code,
   output logic                    busy,
   output logic                    done,
   output adss_pkg::adss_code_t    code
);
   import adss_pkg::*;

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_reg;
   logic          at_end;

   // Abort wins over a new start so a stopped scan leaves nothing running
   assign at_end = busy && (cnt_reg == LAST);

   // Conversion counter
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy    <= 1'b0;
         cnt_reg <= '0;
         done    <= 1'b0;
         code    <= `ADSS_RES_RST;
      end else begin
         done <= at_end && !abort;
         if (abort || at_end) begin
            busy <= 1'b0;
         end else if (go) begin
            busy    <= 1'b1;
            cnt_reg <= '0;
         end else if (busy) begin
            cnt_reg <= cnt_reg + 1'b1;
         end
         if (at_end && !abort) begin
            code <= analog_code;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_conv_duration: assert property (done |-> $past(busy) && $past(cnt_reg) == LAST) // R6
      else $error("done without a full conversion count");
   a_count_bound: assert property (busy |-> cnt_reg <= LAST) // R6
      else $error("conversion counter ran past its end");
endmodule

// [rtl/adss_sequencer.sv]
/*
 Scan sequencer of a 10-bit converter module: register port, start sources, single,
 continuous-scan and one-cycle-scan modes, per-channel result words, end flag,
 interrupt level and transfer request.
 Assumes the analog front end converts the channel on analog_chan_sel while analog_sample
 is high, that timer_trig is a one-cycle pulse on clk, and ext_trig_pin is asynchronous.
*/
`timescale 1ns/1ps
`include "adss_map.svh"

// Behaviour
// [R1] Result word holds the 10-bit code in bits 15..6; bits 5..0 read zero.
// [R2] One 16-bit read-only result word per analog channel.
// [R3] Single mode converts only the selected channel.
// [R4] Continuous scan repeats the channel group until software stops it.
// [R5] One-cycle scan converts the group once, as a third mode.
// [R6] Each channel conversion takes a fixed count of peripheral clocks.
// [R7] Writing 1 to the start bit begins conversion in the chosen mode.
// [R8] End flag is set when the last channel of the pass completes.
// [R9] Continuous scan keeps the start bit set after every pass.
// [R10] Start comes from software, the timer trigger, or the external trigger.
// [R11] External trigger acts only when enabled in the trigger select register.
// [R12] An end-of-conversion interrupt request follows the end flag.
// [R13] A transfer request pulses at each pass end for the transfer controllers.
// [R14] Standby halts the module under software control.
// [R15] Software stops continuous scan by writing 0 to the start bit.
// [R16] Software clears the end flag before reading a pass's results.
// [R17] Scan passes begin at analog input 0.
// [R18] Outside continuous scan the start bit clears itself at pass end.
// [R19] Channels go in ascending order; each result updates on its completion.
// [R20] End flag holds until software writes 0; a new pass end sets it again.
module adss_sequencer #(
   parameter int NCH = 8
) (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic [7:0]           bus_addr,
   input  wire logic [15:0]          bus_wdata,
   input  wire logic                 bus_wr,
   input  wire logic                 bus_rd,
   output logic      [15:0]          bus_rdata,
   input  wire logic                 timer_trig,
   input  wire logic                 ext_trig_pin,
   input  wire adss_pkg::adss_code_t analog_code,
   output logic      [2:0]           analog_chan_sel,
   output logic                      analog_sample,
   output logic                      conv_end_irq,
   output logic                      dma_req
);
   import adss_pkg::*;

   adss_state_e state_reg, state_next;
   logic        start_reg, start_next, stby_reg, stby_next;
   logic [1:0]  mode_reg;
   logic        flag_reg, flag_next, ie_reg;
   logic [2:0]  chsel_reg, chan_reg, chan_next;
   logic        ext_en_reg, tmr_en_reg;
   logic        go_reg, go_next;
   logic        ext_s1, ext_s2, ext_s3, ext_stable_reg;
   logic [15:0] rdata_next;
   adss_code_t  result_reg [NCH];
   adss_code_t  conv_code;
   logic        conv_done;

   // Address decode
   wire wr_ctrl  = bus_wr && (bus_addr == `ADSS_ADDR_CTRL);
   wire wr_stat  = bus_wr && (bus_addr == `ADSS_ADDR_STAT);
   wire wr_trig  = bus_wr && (bus_addr == `ADSS_ADDR_TRIG);
   wire [7:0] res_off = bus_addr - `ADSS_ADDR_RES0;
   wire is_res   = (bus_addr >= `ADSS_ADDR_RES0) && (res_off < 8'(NCH));

   // Mode and sequencing terms; the group of a scan is channels 0 up to chsel
   wire is_cont    = (mode_reg == `ADSS_MODE_CONT);
   wire is_scan    = (mode_reg != `ADSS_MODE_SINGLE);
   wire [2:0] first_chan = is_scan ? 3'h0 : chsel_reg;          // R17 R3
   // A stop that lands on a finishing conversion drops it, so an aborted pass sets no flag
   wire step_done  = conv_done && (state_reg == ADSS_CONV) && start_reg;
   wire round_end  = step_done && (chan_reg == chsel_reg);
   wire begin_conv = (state_reg == ADSS_IDLE) && start_reg && !stby_reg;
   wire abort      = (state_reg == ADSS_CONV) && !start_reg;

   // External trigger: counts only once the second and third stages agree
   wire ext_edge = (ext_s2 == ext_s3) && ext_s3 && !ext_stable_reg;
   wire hw_trig  = (ext_edge && ext_en_reg) || (timer_trig && tmr_en_reg); // R10 R11

   // Start bit: standby first, then software write, then triggers, then self-clear at pass end
   always_comb begin
      stby_next = wr_ctrl ? bus_wdata[`ADSS_CTRL_STBY] : stby_reg;
      if (stby_next) begin
         start_next = 1'b0;                                       // R14
      end else if (wr_ctrl) begin
         start_next = bus_wdata[`ADSS_CTRL_START];                // R7 R15
      end else if (hw_trig) begin
         start_next = 1'b1;                                       // R10
      end else if (round_end && !is_cont) begin
         start_next = 1'b0;                                       // R18
      end else begin
         start_next = start_reg;                                  // R9
      end
   end

   // Pass end sets the flag even in the cycle software clears it
   assign flag_next = round_end ? 1'b1 :                          // R8 R20
                      (wr_stat && !bus_wdata[`ADSS_STAT_FLAG]) ? 1'b0 : flag_reg;

   // Sequencer state and channel walk
   always_comb begin
      state_next = state_reg;
      chan_next  = chan_reg;
      go_next    = 1'b0;
      case (state_reg)
         ADSS_IDLE: begin
            if (begin_conv) begin
               state_next = ADSS_CONV;
               chan_next  = first_chan;                           // R17 R3
               go_next    = 1'b1;                                 // R7
            end
         end
         ADSS_CONV: begin
            if (abort) begin
               state_next = ADSS_IDLE;                            // R15 R14
            end else if (round_end && is_cont) begin
               chan_next = 3'h0;                                  // R4
               go_next   = 1'b1;
            end else if (round_end) begin
               state_next = ADSS_IDLE;                            // R5 R3
            end else if (step_done) begin
               chan_next = chan_reg + 3'h1;                       // R19
               go_next   = 1'b1;
            end
         end
         default: state_next = ADSS_IDLE;
      endcase
   end

   // Read mux; result words are left-justified with zero low bits
   assign rdata_next = !bus_rd ? 16'h0000 :
      (bus_addr == `ADSS_ADDR_CTRL) ? {12'h000, stby_reg, mode_reg, start_reg} :
      (bus_addr == `ADSS_ADDR_STAT) ? {11'h000, chsel_reg, ie_reg, flag_reg} :
      (bus_addr == `ADSS_ADDR_TRIG) ? {14'h0000, tmr_en_reg, ext_en_reg} :
      is_res ? {result_reg[res_off[2:0]], 6'h00} : 16'h0000;     // R1 R2

   // Control and status registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         start_reg  <= 1'b0;
         stby_reg   <= 1'b0;
         mode_reg   <= `ADSS_MODE_RST;
         flag_reg   <= 1'b0;
         ie_reg     <= 1'b0;
         chsel_reg  <= `ADSS_CHSEL_RST;
         ext_en_reg <= 1'b0;
         tmr_en_reg <= 1'b0;
      end else begin
         start_reg <= start_next;
         stby_reg  <= stby_next;
         flag_reg  <= flag_next;
         if (wr_ctrl) begin
            mode_reg <= bus_wdata[`ADSS_CTRL_MODE_HI:`ADSS_CTRL_MODE_LO];
         end
         if (wr_stat) begin
            ie_reg    <= bus_wdata[`ADSS_STAT_IE];
            chsel_reg <= bus_wdata[`ADSS_STAT_CH_HI:`ADSS_STAT_CH_LO];
         end
         if (wr_trig) begin
            ext_en_reg <= bus_wdata[`ADSS_TRIG_EXT];
            tmr_en_reg <= bus_wdata[`ADSS_TRIG_TMR];
         end
      end
   end

   // Sequencer, outputs and trigger synchroniser
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg       <= ADSS_IDLE;
         chan_reg        <= 3'h0;
         go_reg          <= 1'b0;
         bus_rdata       <= 16'h0000;
         conv_end_irq    <= 1'b0;
         dma_req         <= 1'b0;
         analog_chan_sel <= 3'h0;
         ext_s1          <= 1'b0;
         ext_s2          <= 1'b0;
         ext_s3          <= 1'b0;
         ext_stable_reg  <= 1'b0;
      end else begin
         state_reg       <= state_next;
         chan_reg        <= chan_next;
         go_reg          <= go_next;
         bus_rdata       <= rdata_next;
         conv_end_irq    <= flag_reg && ie_reg;                   // R12
         dma_req         <= round_end;                            // R13
         analog_chan_sel <= chan_next;
         ext_s1          <= ext_trig_pin;
         ext_s2          <= ext_s1;
         ext_s3          <= ext_s2;
         if (ext_s2 == ext_s3) begin
            ext_stable_reg <= ext_s3;
         end
      end
   end

   // One result word per channel; writes to these addresses are ignored
   for (genvar i = 0; i < NCH; i++) begin : g_res
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            result_reg[i] <= `ADSS_RES_RST;
         end else if (step_done && (chan_reg == 3'(i))) begin
            result_reg[i] <= conv_code;                           // R19 R2
         end
      end
   end

   // Conversion timing; the analog sample strobe is the timer's busy flop
   adss_conv_timer #(
      .CYCLES      (`ADSS_CONV_CYCLES)
   ) u_timer (
      .clk         (clk),
      .reset_n     (reset_n),
      .go          (go_reg),
      .abort       (abort),
      .analog_code (analog_code),
      .busy        (analog_sample),
      .done        (conv_done),
      .code        (conv_code)
   );

   // Checks run on the one clock and sleep while reset is held
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Named sequences: pass end and scan start over two cycles, stop and hardware start in one
   sequence s_pass_end;
      round_end ##1 1'b1;
   endsequence
   sequence s_scan_begin;
      begin_conv && is_scan ##1 1'b1;
   endsequence
   sequence s_abort;
      state_reg == ADSS_CONV && !start_reg;
   endsequence
   sequence s_hw_start;
      state_reg == ADSS_IDLE && hw_trig && !wr_ctrl && !stby_reg;
   endsequence

   // Result words and channel walk
   a_low_bits_zero: assert property (bus_rd && is_res |=> bus_rdata[5:0] == 6'h00) // R1
      else $error("result low bits not zero");
   a_single_channel: assert property ( // R3
         state_reg == ADSS_CONV && start_reg && !is_scan |-> chan_reg == chsel_reg)
      else $error("single mode left the selected channel");
   a_scan_from_zero: assert property (s_scan_begin |-> chan_reg == 3'h0) // R17
      else $error("scan did not begin at input 0");
   a_ascending: assert property ( // R19
         step_done && !round_end && start_reg |=> chan_reg == $past(chan_reg) + 3'h1)
      else $error("channel order not ascending");
   a_result_capture: assert property ( // R19
         step_done |=> result_reg[$past(chan_reg)] == $past(conv_code))
      else $error("result word not updated on completion");
   a_sel_steady: assert property ( // R19
         analog_sample && $past(analog_sample) |-> $stable(analog_chan_sel))
      else $error("channel select moved while sampling");

   // Conversion strobe
   a_go_samples: assert property (go_reg && !abort |=> analog_sample) // R6
      else $error("conversion did not start after go");
   a_idle_quiet: assert property (state_reg == ADSS_IDLE |-> !analog_sample) // R18
      else $error("sampling while the sequencer is idle");

   // Start bit, flag, interrupt and request
   a_cont_keeps_start: assert property ( // R9
         round_end && is_cont && !wr_ctrl && !stby_reg
         |=> start_reg && state_reg == ADSS_CONV && chan_reg == 3'h0)
      else $error("continuous scan stopped on its own");
   a_auto_clear: assert property ( // R18
         round_end && !is_cont && !wr_ctrl && !hw_trig
         |=> !start_reg ##1 state_reg == ADSS_IDLE)
      else $error("start bit not cleared at pass end");
   a_flag_set: assert property (s_pass_end |-> flag_reg && dma_req) // R8
      else $error("pass end did not set flag and request");
   a_flag_hold: assert property ( // R20
         flag_reg && !(wr_stat && !bus_wdata[`ADSS_STAT_FLAG]) |=> flag_reg)
      else $error("end flag dropped without a clear");
   a_flag_clear: assert property ( // R20
         wr_stat && !bus_wdata[`ADSS_STAT_FLAG] && !round_end |=> !flag_reg)
      else $error("end flag not cleared by software");
   a_irq_follow: assert property (flag_reg && ie_reg |=> conv_end_irq) // R12
      else $error("interrupt not raised for set flag");
   a_irq_drop: assert property (!(flag_reg && ie_reg) |=> !conv_end_irq) // R12
      else $error("interrupt raised without set flag");
   a_dma_single: assert property (dma_req |=> !dma_req) // R13
      else $error("transfer request longer than one cycle");

   // Sources, stop and standby
   a_ext_gated: assert property ( // R11
         state_reg == ADSS_IDLE && !start_reg && !ext_en_reg
         && !(timer_trig && tmr_en_reg) && !wr_ctrl |=> !start_reg)
      else $error("start without an enabled source");
   a_trig_starts: assert property (s_hw_start |=> start_reg) // R10
      else $error("enabled trigger did not set the start bit");
   a_stop_aborts: assert property ( // R15
         s_abort |=> state_reg == ADSS_IDLE && !analog_sample && !dma_req)
      else $error("stop left a conversion running");
   a_standby_halt: assert property (stby_reg |-> !start_reg ##1 state_reg == ADSS_IDLE) // R14
      else $error("converter active in standby");
endmodule

// [verification/adss_front_model.sv]
/*
 Analog front end stand-in: returns a channel-dependent 10-bit code while sampling.
 Assumes the sequencer holds analog_chan_sel steady while analog_sample is high.
*/
`timescale 1ns/1ps

module adss_front_model (
   input  wire logic [2:0]           analog_chan_sel,
   input  wire logic                 analog_sample,
   output adss_pkg::adss_code_t      analog_code
);
   import adss_pkg::*;

   // Code is the channel number over a fixed pattern; inverted between samples
   // so a sequencer that captures at the wrong moment stores a wrong word
   assign analog_code = analog_sample ? {analog_chan_sel, 7'h2A} : ~{analog_chan_sel, 7'h2A};
endmodule

// [verification/adss_sequencer_tb_top.sv]
/*
 Self-checking bench of the scan sequencer: register tasks, mode, trigger and standby tests.
 Assumes adss_map.svh offsets and a 100 ns clock; the front end model supplies codes.
*/
`timescale 1ns/1ps
`include "adss_map.svh"

module adss_sequencer_tb_top;
   import adss_pkg::*;

   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  bus_addr = 8'h00;
   logic [15:0] bus_wdata = 16'h0000;
   logic        bus_wr = 1'b0;
   logic        bus_rd = 1'b0;
   logic [15:0] bus_rdata;
   logic        timer_trig = 1'b0;
   logic        ext_trig_pin = 1'b0;
   adss_code_t  analog_code;
   logic [2:0]  analog_chan_sel;
   logic        analog_sample;
   logic        conv_end_irq;
   logic        dma_req;
   int          n_mismatch = 0;
   int          checks_done = 0;
   int          run_len = 0;
   int          last_run = 0;
   int          n_dma = 0;
   logic        prev_sample = 1'b0;
   logic [2:0]  chans [$];
   logic [15:0] d;

   adss_sequencer #(.NCH(8)) uut (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .timer_trig(timer_trig), .ext_trig_pin(ext_trig_pin), .analog_code(analog_code),
      .analog_chan_sel(analog_chan_sel), .analog_sample(analog_sample),
      .conv_end_irq(conv_end_irq), .dma_req(dma_req));

   adss_front_model front (.analog_chan_sel(analog_chan_sel), .analog_sample(analog_sample),
      .analog_code(analog_code));

   initial begin
      forever #50 clk = ~clk;
   end

   // Monitor: channel order at each sample start, sample length, transfer pulses
   always @(posedge clk) begin
      prev_sample <= analog_sample;
      if (analog_sample === 1'b1 && prev_sample !== 1'b1) chans.push_back(analog_chan_sel);
      if (analog_sample === 1'b1) run_len <= run_len + 1;
      else if (prev_sample === 1'b1) begin
         last_run <= run_len;
         run_len <= 0;
      end
      if (dma_req === 1'b1) n_dma <= n_dma + 1;
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= v;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 v = bus_rdata;
   endtask

   // Poll the end flag under a bounded count
   task automatic wait_flag();
      int i;
      v_loop: for (i = 0; i < 300; i++) begin
         rd(`ADSS_ADDR_STAT, d);
         if (d[0] === 1'b1) break;
      end
      chk("end flag set", {15'h0, d[0]}, 16'h0001);
   endtask

   task automatic print_verdict();
      $display("mismatches %0d, comparisons %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #2000000;
      n_mismatch++;
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      // Reset values, unmapped read, write to a read-only result word
      rd(`ADSS_ADDR_CTRL, d); chk("ctrl reset", d, 16'h0000);
      rd(`ADSS_ADDR_STAT, d); chk("stat reset", d, 16'h0000);
      rd(8'h20, d); chk("unmapped read", d, 16'h0000);
      wr(`ADSS_ADDR_RES0, 16'hFFFF);
      rd(`ADSS_ADDR_RES0, d); chk("result read-only", d, 16'h0000);
      // Single mode on channel 2 with interrupt enabled
      wr(`ADSS_ADDR_STAT, 16'h000A);
      wr(`ADSS_ADDR_CTRL, 16'h0001);
      wait_flag();
      chk("single channel", {13'h0, chans[0]}, 16'h0002);
      chk("single count", chans.size(), 16'h0001);
      chk("conv length", last_run, 16'h0032);
      rd(8'h0A, d); chk("result 2", d, {3'h2, 7'h2A, 6'h00});
      rd(8'h08, d); chk("result 0 untouched", d, 16'h0000);
      rd(`ADSS_ADDR_CTRL, d); chk("start self-clear", d, 16'h0000);
      chk("irq level", {15'h0, conv_end_irq}, 16'h0001);
      chk("dma pulses", n_dma, 16'h0001);
      wr(`ADSS_ADDR_STAT, 16'h000A);
      rd(`ADSS_ADDR_STAT, d); chk("flag clear", d, 16'h000A);
      chk("irq cleared", {15'h0, conv_end_irq}, 16'h0000);
      // One-cycle scan over channels 0..3
      chans = {};
      wr(`ADSS_ADDR_STAT, 16'h000C);
      wr(`ADSS_ADDR_CTRL, 16'h0005);
      wait_flag();
      chk("scan count", chans.size(), 16'h0004);
      foreach (chans[i]) chk("scan order", {13'h0, chans[i]}, i);
      for (int i = 0; i < 4; i++) begin
         rd(8'(8'h08 + i), d); chk("scan result", d, {i[2:0], 7'h2A, 6'h00});
      end
      rd(`ADSS_ADDR_CTRL, d); chk("one-cycle self-clear", d, 16'h0004);
      chk("dma per pass", n_dma, 16'h0002);
      // Continuous scan over channels 0..1, two passes, then stop
      wr(`ADSS_ADDR_STAT, 16'h0004);
      wr(`ADSS_ADDR_CTRL, 16'h0003);
      wait_flag();
      wr(`ADSS_ADDR_STAT, 16'h0004);
      rd(`ADSS_ADDR_CTRL, d); chk("start kept", d, 16'h0003);
      wait_flag();
      wr(`ADSS_ADDR_CTRL, 16'h0000);
      repeat (3) @(posedge clk);
      chans = {};
      repeat (60) @(posedge clk);
      chk("stopped", chans.size(), 16'h0000);
      // External trigger ignored while disabled, then accepted; then timer trigger
      wr(`ADSS_ADDR_STAT, 16'h0000);
      @(posedge clk) ext_trig_pin <= 1'b1;
      repeat (6) @(posedge clk);
      ext_trig_pin <= 1'b0;
      repeat (60) @(posedge clk);
      chk("ext disabled", chans.size(), 16'h0000);
      wr(`ADSS_ADDR_TRIG, 16'h0001);
      rd(`ADSS_ADDR_TRIG, d); chk("trigger select", d, 16'h0001);
      @(posedge clk) ext_trig_pin <= 1'b1;
      repeat (6) @(posedge clk);
      ext_trig_pin <= 1'b0;
      wait_flag();
      wr(`ADSS_ADDR_STAT, 16'h0000);
      wr(`ADSS_ADDR_TRIG, 16'h0002);
      @(posedge clk) timer_trig <= 1'b1;
      @(posedge clk) timer_trig <= 1'b0;
      wait_flag();
      // Mode code 3 acts as a one-cycle scan, here over channels 0..1
      chans = {};
      wr(`ADSS_ADDR_STAT, 16'h0004);
      wr(`ADSS_ADDR_CTRL, 16'h0007);
      wait_flag();
      chk("mode 3 count", chans.size(), 16'h0002);
      rd(`ADSS_ADDR_CTRL, d); chk("mode 3 self-clear", d, 16'h0006);
      // Standby refuses a start
      chans = {};
      wr(`ADSS_ADDR_CTRL, 16'h0009);
      rd(`ADSS_ADDR_CTRL, d); chk("standby start", d, 16'h0008);
      repeat (30) @(posedge clk);
      chk("standby idle", chans.size(), 16'h0000);
      print_verdict();
   end
endmodule
